// ===== logic/dead_band_pair.sv
// Complementary pair generator with dead-band insertion
`timescale 1ns/1ps
`default_nettype none
module dead_band_pair
  import enhanced_timing_unit_steer_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic clear,
  input wire logic [6:0] dead_band,
  // Waveform in, pair out
  input wire logic pwm_in,
  output logic a_on,
  output logic b_on
);
  typedef struct packed {
    logic [6:0] count;
    logic last;
    logic a_on;
    logic b_on;
  } db_state_t;

  db_state_t s_r;
  db_state_t s_nxt;

  // Both sides go off on every edge, so a slow driver never shoots through
  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.count = 7'h00;
      s_nxt.last = pwm_in;
      s_nxt.a_on = 1'b0;
      s_nxt.b_on = 1'b0;
    end else if (pwm_in != s_r.last) begin
      s_nxt.last = pwm_in;
      s_nxt.a_on = 1'b0;
      s_nxt.b_on = 1'b0;
      s_nxt.count = dead_band;
    end else if (s_r.count != 7'h00) begin
      s_nxt.count = s_r.count - 7'h01;
    end else begin
      s_nxt.a_on = s_r.last;
      s_nxt.b_on = ~s_r.last;
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign a_on = s_r.a_on;
  assign b_on = s_r.b_on;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_no_overlap;
    !(s_r.a_on && s_r.b_on);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair both on");
endmodule
`default_nettype wire

// ===== logic/enhanced_timing_unit_output_steer.sv
// Enhanced capture/compare/PWM unit with output steering and register port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - PWM single output: only A modulated, B, C, D left to port pins.
// - PWM forward bridge: D modulated, A active, B and C inactive.
// - PWM half bridge: A and B complementary with dead band; C, D port pins.
// - Control bits 5-4 are duty-cycle low bits, ignored in capture mode.
// - Mode 0000 switches everything off and resets the unit.
// - Mode 0111 captures on every sixteenth rising capture edge.
module enhanced_timing_unit_output_steer
  import enhanced_timing_unit_steer_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [2:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // Capture pin
  input wire logic capture_in,
  // Steered outputs, drive enables low while the unit owns the pin
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic [3:0] drive_n
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] duty_high;
    logic [7:0] period;
    logic [6:0] dead_band;
    logic [15:0] value;
    logic [15:0] timer;
    logic [9:0] pwm_count;
    logic [2:0] sync;
    logic cap_level;
    logic [3:0] cap_pre;
    logic cmp_out;
    logic event_flag;
    logic [3:0] pins;
    logic [3:0] drive_n;
    logic [7:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [3:0] mode;
  logic [1:0] steer;
  logic [1:0] duty_low;
  kind_t kind;
  logic inv_ac;
  logic inv_bd;
  logic stable;
  logic rise;
  logic fall;
  logic pwm_raw;
  logic db_a;
  logic db_b;
  logic db_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the control register
  assign mode = s_r.control[MODE_MSB:MODE_LSB];
  assign steer = s_r.control[STEER_MSB:STEER_LSB];
  assign duty_low = s_r.control[DUTY_LOW_MSB:DUTY_LOW_LSB];
  assign kind = unit_kind(mode);
  // Polarity bits only mean something in PWM
  assign inv_ac = (kind == KIND_PWM) && mode[1];
  assign inv_bd = (kind == KIND_PWM) && mode[0];
  // Capture pin counts only once two later stages agree
  assign stable = (s_r.sync[1] == s_r.sync[2]);
  assign rise = stable && s_r.sync[2] && !s_r.cap_level;
  assign fall = stable && !s_r.sync[2] && s_r.cap_level;
  assign pwm_raw = (kind == KIND_PWM) && (s_r.pwm_count < {s_r.duty_high, duty_low});
  assign db_clear = !((kind == KIND_PWM) && (steer == STEER_HALF));

  ////////////////////////////////////////////////////////////////////////////
  // Dead-band pair for the half bridge
  dead_band_pair u_dead_band (
    .clock(clock),
    .arst_n(arst_n),
    .clear(db_clear),
    .dead_band(s_r.dead_band),
    .pwm_in(pwm_raw),
    .a_on(db_a),
    .b_on(db_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.sync = {s_r.sync[1:0], capture_in};
    if (stable) begin
      s_nxt.cap_level = s_r.sync[2];
    end
    // Time base and waveform counter
    s_nxt.timer = s_r.timer + 16'h0001;
    if (kind == KIND_PWM) begin
      if (s_r.pwm_count == {s_r.period, 2'h3}) begin
        s_nxt.pwm_count = 10'h000;
      end else begin
        s_nxt.pwm_count = s_r.pwm_count + 10'h001;
      end
    end
    // Status clear goes first so that an event in the same cycle overrides it
    if (write_strobe && address == ADDR_STATUS && write_data[STATUS_EVENT_BIT]) begin
      s_nxt.event_flag = 1'b0;
    end
    if (kind == KIND_CAPTURE) begin
      if ((mode == MODE_CAP_FALL && fall) || (mode == MODE_CAP_RISE && rise)) begin
        s_nxt.value = s_r.timer;
        s_nxt.event_flag = 1'b1;
      end else if ((mode == MODE_CAP_4TH || mode == MODE_CAP_16TH) && rise) begin
        if (s_r.cap_pre == ((mode == MODE_CAP_4TH) ? CAP_PRESCALE_4 : CAP_PRESCALE_16)) begin
          s_nxt.cap_pre = 4'h0;
          s_nxt.value = s_r.timer;
          s_nxt.event_flag = 1'b1;
        end else begin
          s_nxt.cap_pre = s_r.cap_pre + 4'h1;
        end
      end
    end
    // Compare match actions
    if (kind == KIND_COMPARE && s_r.timer == s_r.value) begin
      s_nxt.event_flag = 1'b1;
      unique case (mode)
        MODE_CMP_SET: s_nxt.cmp_out = 1'b1;
        MODE_CMP_CLEAR: s_nxt.cmp_out = 1'b0;
        MODE_CMP_TOGGLE: s_nxt.cmp_out = ~s_r.cmp_out;
        MODE_CMP_SPECIAL: s_nxt.timer = 16'h0000;
        default: s_nxt.cmp_out = s_r.cmp_out;
      endcase
    end
    // Register writes; a status write of one clears the event, a new event wins
    if (write_strobe) begin
      unique case (address)
        ADDR_CONTROL: s_nxt.control = write_data;
        ADDR_DUTY_HIGH: s_nxt.duty_high = write_data;
        ADDR_PERIOD: s_nxt.period = write_data;
        ADDR_DEAD_BAND: s_nxt.dead_band = write_data[6:0];
        ADDR_VALUE_LOW: s_nxt.value[7:0] = write_data;
        ADDR_VALUE_HIGH: s_nxt.value[15:8] = write_data;
        // Clear already taken above the event logic
        ADDR_STATUS: s_nxt.event_flag = s_nxt.event_flag;
        default: s_nxt.control = s_nxt.control;
      endcase
    end
    // Register reads, unmapped addresses answer zero
    if (read_strobe) begin
      unique case (address)
        ADDR_CONTROL: s_nxt.rdata = s_r.control;
        ADDR_DUTY_HIGH: s_nxt.rdata = s_r.duty_high;
        ADDR_PERIOD: s_nxt.rdata = s_r.period;
        ADDR_DEAD_BAND: s_nxt.rdata = {1'b0, s_r.dead_band};
        ADDR_VALUE_LOW: s_nxt.rdata = s_r.value[7:0];
        ADDR_VALUE_HIGH: s_nxt.rdata = s_r.value[15:8];
        ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.cap_level, s_r.event_flag};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // unit held at reset while switched off
    if (kind == KIND_OFF) begin
      s_nxt.timer = 16'h0000;
      s_nxt.pwm_count = 10'h000;
      s_nxt.cap_pre = 4'h0;
      s_nxt.cmp_out = 1'b0;
    end
    // Output steering; bit 0 is A up to bit 3 for D
    unique case (kind)
      KIND_PWM: begin
        unique case (steer)
          STEER_SINGLE: begin
            s_nxt.pins = {inv_bd, inv_ac, inv_bd, pwm_raw ^ inv_ac};
            s_nxt.drive_n = 4'hE;
          end
          STEER_FWD: begin
            s_nxt.pins = {pwm_raw ^ inv_bd, inv_ac, inv_bd, ~inv_ac};
            s_nxt.drive_n = 4'h0;
          end
          STEER_HALF: begin
            s_nxt.pins = {inv_bd, inv_ac, db_b ^ inv_bd, db_a ^ inv_ac};
            s_nxt.drive_n = 4'hC;
          end
          STEER_REV: begin
            s_nxt.pins = {inv_bd, ~inv_ac, pwm_raw ^ inv_bd, inv_ac};
            s_nxt.drive_n = 4'h0;
          end
        endcase
      end
      KIND_COMPARE: begin
        s_nxt.pins = {3'h0, s_r.cmp_out};
        s_nxt.drive_n = 4'hE;
      end
      // capture listens on A, so nothing is driven
      KIND_CAPTURE: begin
        s_nxt.pins = 4'h0;
        s_nxt.drive_n = 4'hF;
      end
      KIND_OFF: begin
        s_nxt.pins = 4'h0;
        s_nxt.drive_n = 4'hF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{control: CONTROL_RESET, duty_high: DUTY_HIGH_RESET, period: PERIOD_RESET,
               dead_band: DEAD_BAND_RESET, value: VALUE_RESET, drive_n: 4'hF, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign read_data = s_r.rdata;
  assign pwm_out_a = s_r.pins[0];
  assign pwm_out_b = s_r.pins[1];
  assign pwm_out_c = s_r.pins[2];
  assign pwm_out_d = s_r.pins[3];
  assign drive_n = s_r.drive_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_sixteenth_edge;
    (kind == KIND_CAPTURE) && (mode == MODE_CAP_16TH) && rise && (s_r.cap_pre == 4'hF);
  endsequence
  sequence s_counted_edge;
    (kind == KIND_CAPTURE) && (mode == MODE_CAP_16TH) && rise && (s_r.cap_pre != 4'hF);
  endsequence

  property p_non_pwm_release;
    (kind != KIND_PWM) |=> (drive_n[3:1] == 3'h7);
  endproperty
  a_non_pwm_release: assert property (p_non_pwm_release) else $error("B-D not released");
  property p_single;
    (kind == KIND_PWM && steer == STEER_SINGLE) |=> (drive_n == 4'hE);
  endproperty
  a_single: assert property (p_single) else $error("single output wrong");
  property p_forward;
    (kind == KIND_PWM && steer == STEER_FWD) |=>
      (drive_n == 4'h0 && pwm_out_a == !$past(mode[1]) && pwm_out_b == $past(mode[0]));
  endproperty
  a_forward: assert property (p_forward) else $error("forward bridge wrong");
  property p_half;
    (kind == KIND_PWM && steer == STEER_HALF) |=> (drive_n == 4'hC);
  endproperty
  a_half: assert property (p_half) else $error("half bridge wrong");
  property p_duty_end;
    (kind == KIND_PWM && steer == STEER_SINGLE && s_r.pwm_count != 10'h000 &&
     s_r.pwm_count == {s_r.duty_high, duty_low}) |=> (pwm_out_a == $past(mode[1]));
  endproperty
  a_duty_end: assert property (p_duty_end) else $error("duty end wrong");
  property p_reverse;
    (kind == KIND_PWM && steer == STEER_REV) |=>
      (drive_n == 4'h0 && pwm_out_c == !$past(mode[1]) && pwm_out_d == $past(mode[0]));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse bridge wrong");
  property p_off_reset;
    (kind == KIND_OFF) |=> (s_r.timer == 16'h0000 && s_r.pwm_count == 10'h000 && drive_n == 4'hF);
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("off mode not reset");
  property p_sixteenth;
    s_sixteenth_edge ##0 !(write_strobe && address[2]) |=>
      (s_r.event_flag && s_r.cap_pre == 4'h0 && s_r.value == $past(s_r.timer));
  endproperty
  a_sixteenth: assert property (p_sixteenth) else $error("16th edge missed");
  property p_counted;
    s_counted_edge ##0 !write_strobe |=> (s_r.cap_pre == 4'($past(s_r.cap_pre) + 4'h1));
  endproperty
  a_counted: assert property (p_counted) else $error("edge not counted");
endmodule
`default_nettype wire

// ===== pkg/enhanced_timing_unit_steer_pkg.sv
// Constants, types and mode decoding shared by the output steering unit
package enhanced_timing_unit_steer_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_DUTY_HIGH = 3'h1;
  localparam logic [2:0] ADDR_PERIOD = 3'h2;
  localparam logic [2:0] ADDR_DEAD_BAND = 3'h3;
  localparam logic [2:0] ADDR_VALUE_LOW = 3'h4;
  localparam logic [2:0] ADDR_VALUE_HIGH = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  // Field positions of the control and status registers
  localparam int STEER_MSB = 7;
  localparam int STEER_LSB = 6;
  localparam int DUTY_LOW_MSB = 5;
  localparam int DUTY_LOW_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 0;
  localparam int STATUS_EVENT_BIT = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DUTY_HIGH_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [6:0] DEAD_BAND_RESET = 7'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Mode select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  // Output configuration codes
  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD = 2'h1;
  localparam logic [1:0] STEER_HALF = 2'h2;
  localparam logic [1:0] STEER_REV = 2'h3;
  // Capture prescaler terminal counts (edges minus one)
  localparam logic [3:0] CAP_PRESCALE_4 = 4'h3;
  localparam logic [3:0] CAP_PRESCALE_16 = 4'hF;

  typedef enum logic [1:0] {KIND_OFF, KIND_CAPTURE, KIND_COMPARE, KIND_PWM} kind_t;

  // Broad operating kind from the mode select code
  function automatic kind_t unit_kind(input logic [3:0] mode);
    kind_t k;
    k = KIND_OFF;
    if (mode[3:2] == 2'h3) begin
      k = KIND_PWM;
    end else if (mode == MODE_CAP_FALL || mode == MODE_CAP_RISE ||
                 mode == MODE_CAP_4TH || mode == MODE_CAP_16TH) begin
      k = KIND_CAPTURE;
    end else if (mode == MODE_CMP_TOGGLE || mode[3:2] == 2'h2) begin
      k = KIND_COMPARE;
    end
    return k;
  endfunction
endpackage

// ===== sim/bridge_driver_model.sv
// Model of the external bridge drivers and the capture signal source
`timescale 1ns/1ps
`default_nettype none
module bridge_driver_model (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Steered pins from the unit
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire logic [3:0] drive_n,
  // Capture source
  input wire logic pulse_req,
  output logic capture_in,
  // Wire levels and fault flag
  output logic [3:0] pin_level,
  output logic shoot_through
);
  logic [3:0] burst_r;
  ////////////////////////////////////////////////////////////////////////////
  // Released pins fall to the port pull-down, never keep the last value
  assign pin_level = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} & ~drive_n;
  // High four cycles then low four, long enough for the synchroniser
  assign capture_in = (burst_r > 4'h4);
  ////////////////////////////////////////////////////////////////////////////
  // capture burst counter and shoot-through watch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      burst_r <= 4'h0;
      shoot_through <= 1'b0;
    end else begin
      if (pulse_req && burst_r == 4'h0) begin
        burst_r <= 4'h8;
      end else if (burst_r != 4'h0) begin
        burst_r <= burst_r - 4'h1;
      end
      // Both half-bridge switches on at once would short the supply
      if (drive_n == 4'hC && pin_level[1:0] == 2'h3) begin
        shoot_through <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/enhanced_ccp_output_steering_control_bench.sv
// Self-checking bench for the steered output unit
`timescale 1ns/1ps
`default_nettype none
module enhanced_ccp_output_steering_control_bench
  import enhanced_timing_unit_steer_pkg::*;
;
  logic clock;
  logic arst_n;
  logic [2:0] address;
  logic [7:0] write_data;
  logic [7:0] read_data;
  logic write_strobe;
  logic read_strobe;
  logic capture_in;
  logic pulse_req;
  logic shoot_through;
  logic pwm_out_a;
  logic pwm_out_b;
  logic pwm_out_c;
  logic pwm_out_d;
  logic [3:0] drive_n;
  logic [3:0] pin_level;
  int n_mismatch = 0;
  int compares = 0;
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] steer;
    logic full;
    logic [3:0] dn;
    logic [3:0] lvl;
    logic [3:0] m;
  } row_t;
  // Mode, steering, full duty, drive enables, wire levels, mask
  row_t rows [13] = '{
    '{4'hC, 2'h0, 1'b0, 4'hE, 4'h0, 4'hF},
    '{4'hC, 2'h1, 1'b0, 4'h0, 4'h1, 4'hF},
    '{4'hC, 2'h2, 1'b0, 4'hC, 4'h2, 4'hF},
    '{4'hC, 2'h3, 1'b0, 4'h0, 4'h4, 4'hF},
    '{4'hF, 2'h1, 1'b0, 4'h0, 4'hE, 4'hF},
    '{4'hF, 2'h3, 1'b0, 4'h0, 4'hB, 4'hF},
    '{4'hC, 2'h1, 1'b1, 4'h0, 4'h9, 4'hF},
    '{4'hC, 2'h2, 1'b1, 4'hC, 4'h1, 4'hF},
    '{4'hD, 2'h0, 1'b1, 4'hE, 4'h1, 4'hF},
    '{4'hE, 2'h3, 1'b1, 4'h0, 4'h3, 4'hF},
    '{4'h5, 2'h3, 1'b1, 4'hE, 4'h0, 4'hE},
    '{4'h0, 2'h3, 1'b1, 4'hF, 4'h0, 4'hF},
    '{4'h8, 2'h2, 1'b1, 4'hE, 4'h0, 4'hE}
  };
  ////////////////////////////////////////////////////////////////////////////
  // Unit and far-side model
  enhanced_timing_unit_output_steer enhanced_timing_unit_output_steer_i (
    .clock(clock), .arst_n(arst_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .capture_in(capture_in), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .drive_n(drive_n)
  );
  bridge_driver_model bridge_driver_model_i (
    .clock(clock), .arst_n(arst_n), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .drive_n(drive_n),
    .pulse_req(pulse_req), .capture_in(capture_in), .pin_level(pin_level),
    .shoot_through(shoot_through)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clock);
      pulse_req <= 1'b1;
      @(posedge clock);
      pulse_req <= 1'b0;
      repeat (8) @(posedge clock);
    end
  endtask
  task automatic complete_run();
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the normal run length
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("MISMATCH run length expected finish seen limit");
    complete_run();
  end
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [3:0] m;
    int hi_a;
    int hi_b;
    arst_n = 1'b0;
    address = 3'h0;
    write_data = 8'h00;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    pulse_req = 1'b0;
    repeat (5) @(posedge clock);
    #1 chk("drive_n in reset", 8'h0F, {4'h0, drive_n});
    chk("pins in reset", 8'h00, {4'h0, pin_level});
    $display("test reset finished");
    arst_n <= 1'b1;
    // Reset values, unmapped index reads as zero
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      chk("reset read", 8'h00, v);
    end
    wr(ADDR_CONTROL, 8'hA5);
    rd(ADDR_CONTROL, v);
    chk("control read back", 8'hA5, v);
    @(posedge clock);
    #1 chk("read data idle", 8'h00, read_data);
    wr(3'h7, 8'h5A);
    rd(3'h7, v);
    chk("unmapped read", 8'h00, v);
    // Dead band keeps seven bits; the value is written one byte at a time
    wr(ADDR_DEAD_BAND, 8'hFF);
    rd(ADDR_DEAD_BAND, v);
    chk("dead band read back", 8'h7F, v);
    wr(ADDR_DEAD_BAND, 8'h00);
    wr(ADDR_VALUE_LOW, 8'h34);
    wr(ADDR_VALUE_HIGH, 8'h12);
    rd(ADDR_VALUE_LOW, v);
    chk("value low read back", 8'h34, v);
    rd(ADDR_VALUE_HIGH, v);
    chk("value high read back", 8'h12, v);
    $display("test registers finished");
    // Steering table, static waveforms only
    foreach (rows[i]) begin
      wr(ADDR_PERIOD, 8'h00);
      wr(ADDR_DUTY_HIGH, rows[i].full ? 8'hFF : 8'h00);
      wr(ADDR_CONTROL, {rows[i].steer, 2'h0, rows[i].mode});
      repeat (8) @(posedge clock);
      #1 chk("drive_n", {4'h0, rows[i].dn & rows[i].m}, {4'h0, drive_n & rows[i].m});
      chk("pin level", {4'h0, rows[i].lvl & rows[i].m}, {4'h0, pin_level & rows[i].m});
    end
    $display("test steering table finished");
    // Duty low bits alone set the on time in a four-count period
    wr(ADDR_DUTY_HIGH, 8'h00);
    for (int d = 1; d < 4; d++) begin
      wr(ADDR_CONTROL, {2'h0, d[1:0], 4'hC});
      repeat (8) @(posedge clock);
      hi_a = 0;
      repeat (8) begin
        @(posedge clock);
        #1 hi_a += pin_level[0];
      end
      chk("duty low on time", 8'(2 * d), 8'(hi_a));
    end
    $display("test duty low finished");
    // Half bridge toggling, one cycle of dead band each change
    wr(ADDR_CONTROL, {STEER_HALF, 2'h2, 4'hC});
    repeat (8) @(posedge clock);
    hi_a = 0;
    hi_b = 0;
    repeat (40) begin
      @(posedge clock);
      #1 hi_a += pin_level[0];
      hi_b += pin_level[1];
    end
    chk("half bridge a on", 8'd10, 8'(hi_a));
    chk("half bridge b on", 8'd10, 8'(hi_b));
    chk("shoot through", 8'h00, {7'h0, shoot_through});
    $display("test half bridge finished");
    // Prescaled capture; off mode must clear a partial count
    for (int k = 0; k < 2; k++) begin
      m = k ? MODE_CAP_16TH : MODE_CAP_4TH;
      wr(ADDR_CONTROL, {4'h0, m});
      pulse(5);
      wr(ADDR_CONTROL, {4'h0, MODE_OFF});
      wr(ADDR_STATUS, 8'h01);
      wr(ADDR_CONTROL, {4'h0, m});
      pulse(k ? 15 : 3);
      rd(ADDR_STATUS, v);
      chk("no capture yet", 8'h00, v);
      pulse(1);
      rd(ADDR_STATUS, v);
      chk("capture event", 8'h01, v);
    end
    $display("test capture finished");
    // Reset in mid-run drops a live bridge back to released pins
    wr(ADDR_CONTROL, 8'h4C);
    repeat (2) @(posedge clock);
    arst_n <= 1'b0;
    @(posedge clock);
    #1 chk("drive_n in mid reset", 8'h0F, {4'h0, drive_n});
    @(posedge clock);
    arst_n <= 1'b1;
    rd(ADDR_CONTROL, v);
    chk("control after reset", 8'h00, v);
    chk("pins after reset", 8'h00, {4'h0, pin_level});
    $display("test mid reset finished");
    complete_run();
  end
endmodule
`default_nettype wire
